// [rtl/nfc_regs.svh]
// Register offsets, field positions, command bytes and timing counts.
`ifndef NFC_REGS_SVH
`define NFC_REGS_SVH
`define NFC_OFS_CTRL 8'h00
`define NFC_OFS_ADDR 8'h04
`define NFC_OFS_WDATA 8'h08
`define NFC_OFS_RDATA 8'h0C
`define NFC_OFS_STAT 8'h10
`define NFC_CTRL_WP_BIT 8
`define NFC_STAT_ERR_BIT 7
`define NFC_CTRL_RST 32'h0000_0000
`define NFC_C_READ 8'h00
`define NFC_C_RDCB 8'h35
`define NFC_C_PROG 8'h80
`define NFC_C_RAND 8'h85
`define NFC_C_CONF 8'h10
`define NFC_C_ERASE 8'h60
`define NFC_C_ERCONF 8'hD0
`define NFC_C_STAT 8'h70
`define NFC_C_ID 8'h90
`define NFC_C_RESET 8'hFF
`define NFC_ID_ADDR 8'h00
`define NFC_PART_MAX 4
`define NFC_CLK_MHZ 50
`define NFC_T_SETUP_NS 15
`define NFC_T_WP_NS 25
`define NFC_T_HOLD_NS 10
`define NFC_T_WB_NS 100
`define NFC_SETUP_CYC ((`NFC_T_SETUP_NS * `NFC_CLK_MHZ + 999) / 1000)
`define NFC_PULSE_CYC ((`NFC_T_WP_NS * `NFC_CLK_MHZ + 999) / 1000)
`define NFC_HOLD_CYC ((`NFC_T_HOLD_NS * `NFC_CLK_MHZ + 999) / 1000)
`define NFC_TWB_CYC ((`NFC_T_WB_NS * `NFC_CLK_MHZ + 999) / 1000)
`endif

// [rtl/nfc_pkg.sv]
// Types shared by the flash host sequencer and its pin cycle engine.
package nfc_pkg;
   typedef enum logic [1:0] {K_CMD, K_ADDR, K_WR, K_RD} nfc_kind_e;
   typedef enum logic [3:0] {OP_NONE, OP_PROG, OP_RAND, OP_CONF, OP_ERASE,
      OP_CBRD, OP_CBPG, OP_STAT, OP_ID, OP_RESET, OP_RDBYTE, OP_RDARR,
      OP_WDATA} nfc_op_e;
   typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAITC} nfc_st_e;
   typedef enum logic [1:0] {P_IDLE, P_SETUP, P_STROBE, P_HOLD} nfc_ph_e;
   typedef struct packed {
      nfc_kind_e kind;
      logic [7:0] data;
      logic last;
   } nfc_cyc_s;
   typedef struct packed {
      logic ce_n;
      logic cle;
      logic ale;
      logic we_n;
      logic re_n;
      logic io_oe_n;
      logic [7:0] io;
   } nfc_pins_s;
   typedef struct packed {
      nfc_ph_e ph;
      logic [3:0] cnt;
      nfc_kind_e kind;
      nfc_pins_s pins;
      logic [7:0] rdata;
      logic done;
   } nfc_eng_s;
   typedef struct packed {
      nfc_st_e st;
      nfc_op_e op;
      logic [2:0] idx;
      logic ack;
      logic [31:0] dat_o;
      logic [27:0] addr;
      logic [7:0] wdata;
      logic [7:0] rdata;
      logic [15:0] page;
      logic [15:0] last_page;
      logic [2:0] part_cnt;
      logic [3:0] wb_cnt;
      logic wp_n;
      logic err;
      logic loading;
      logic loaded;
      logic cb;
      logic stat_mode;
      logic busy;
   } nfc_top_s;
endpackage

// [rtl/nfc_cycle.sv]
// Pin cycle engine: one command, address, write or read strobe cycle.
`include "nfc_regs.svh"
module nfc_cycle #(
   parameter int unsigned SETUP_CYC = `NFC_SETUP_CYC,
   parameter int unsigned PULSE_CYC = `NFC_PULSE_CYC,
   parameter int unsigned HOLD_CYC = `NFC_HOLD_CYC
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic req_i,
   input wire nfc_pkg::nfc_cyc_s cyc_i,
   input wire logic [7:0] io_i,
   output nfc_pkg::nfc_pins_s pins_o,
   output logic [7:0] rdata_o,
   output logic done_o
);
   localparam nfc_pkg::nfc_pins_s PINS_IDLE = '{1'b1, 1'b0, 1'b0, 1'b1,
      1'b1, 1'b1, 8'h00};
   localparam nfc_pkg::nfc_eng_s ENG_RST = '{nfc_pkg::P_IDLE, 4'h0,
      nfc_pkg::K_CMD, PINS_IDLE, 8'h00, 1'b0};
   nfc_pkg::nfc_eng_s q;
   nfc_pkg::nfc_eng_s d;

   always_comb begin
      d = q;
      d.done = 1'b0;
      if (!ce_i) begin
         d = q;
      end else begin
         case (q.ph)
            nfc_pkg::P_IDLE: begin
               if (req_i) begin
                  d.kind = cyc_i.kind;
                  d.pins.ce_n = 1'b0;
                  d.pins.cle = (cyc_i.kind == nfc_pkg::K_CMD);
                  d.pins.ale = (cyc_i.kind == nfc_pkg::K_ADDR);
                  d.pins.io = cyc_i.data;
                  d.pins.io_oe_n = (cyc_i.kind == nfc_pkg::K_RD);
                  d.ph = nfc_pkg::P_SETUP;
                  d.cnt = 4'(SETUP_CYC - 1);
               end
            end
            nfc_pkg::P_SETUP: begin
               if (q.cnt == 4'h0) begin
                  d.ph = nfc_pkg::P_STROBE;
                  d.cnt = 4'(PULSE_CYC - 1);
                  if (q.kind == nfc_pkg::K_RD) begin
                     d.pins.re_n = 1'b0;
                  end else begin
                     d.pins.we_n = 1'b0;
                  end
               end else begin
                  d.cnt = q.cnt - 4'h1;
               end
            end
            nfc_pkg::P_STROBE: begin
               if (q.cnt == 4'h0) begin
                  // Sampling at the end of the low phase leaves the whole
                  // pulse for the flash access time.
                  if (q.kind == nfc_pkg::K_RD) begin
                     d.rdata = io_i;
                  end
                  d.pins.we_n = 1'b1;
                  d.pins.re_n = 1'b1;
                  d.ph = nfc_pkg::P_HOLD;
                  d.cnt = 4'(HOLD_CYC - 1);
               end else begin
                  d.cnt = q.cnt - 4'h1;
               end
            end
            nfc_pkg::P_HOLD: begin
               if (q.cnt == 4'h0) begin
                  d.pins = PINS_IDLE;
                  d.ph = nfc_pkg::P_IDLE;
                  d.done = 1'b1;
               end else begin
                  d.cnt = q.cnt - 4'h1;
               end
            end
            default: begin
               d = ENG_RST;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q <= ENG_RST;
      end else begin
         q <= d;
      end
   end

   assign pins_o = q.pins;
   assign rdata_o = q.rdata;
   assign done_o = q.done;

   default clocking cb_eng @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   a_cmd_latch: assert property (
      ($rose(q.pins.we_n) && q.pins.cle) |->
      (!q.pins.ce_n && !q.pins.ale && q.pins.re_n))
      else $error("Command latched with wrong latch levels.");
   a_addr_latch: assert property (
      ($rose(q.pins.we_n) && q.pins.ale) |->
      (!q.pins.ce_n && !q.pins.cle && q.pins.re_n))
      else $error("Address latched with wrong latch levels.");
endmodule

// [rtl/nfc_host.sv]
// Wishbone controlled host sequencer that drives a NAND flash by its pins.
// Overview of operation
// - Refuse a fifth partial program of one page before an erase; the count restarts at one when a confirm goes to another page.
// - Program opens with 80h, four address cycles, then data bytes.
// - Erase is 60h, two block address cycles, then D0h confirm.
// - When ready, issue 85h, destination address, optional data, 10h.
// - Issue 00h before array reads after a status read.
// - Commands latch on write strobe rise, CLE high, ALE low.
// - A full address takes four cycles latched with ALE high.
//
// Implementation choices: the Wishbone interface to the registers and the placing of the registers.
`include "nfc_regs.svh"
module nfc_host #(
   parameter int unsigned TWB_CYC = `NFC_TWB_CYC,
   parameter int unsigned PART_MAX = `NFC_PART_MAX
) (
   input wire logic SYS_CLK_I,
   input wire logic RSTN_I,
   input wire logic SYS_CE_I,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   output logic NAND_CE_N_O,
   output logic NAND_CLE_O,
   output logic NAND_ALE_O,
   output logic NAND_WE_N_O,
   output logic NAND_RE_N_O,
   output logic NAND_WP_N_O,
   input wire logic [7:0] NAND_IO_I,
   output logic [7:0] NAND_IO_O,
   output logic NAND_IO_OE_N_O,
   input wire logic NAND_RB_N_I
);
   localparam nfc_pkg::nfc_top_s TOP_RST = '{nfc_pkg::S_IDLE,
      nfc_pkg::OP_NONE, 3'h0, 1'b0, 32'h0000_0000, 28'h000_0000, 8'h00,
      8'h00, 16'h0000, 16'hFFFF, 3'h0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0,
      1'b0, 1'b0, 1'b0};
   nfc_pkg::nfc_top_s q;
   nfc_pkg::nfc_top_s d;
   nfc_pkg::nfc_cyc_s cur;
   nfc_pkg::nfc_pins_s pins;
   logic [7:0] eng_rdata;
   logic eng_done;
   logic acc;

   function automatic nfc_pkg::nfc_cyc_s step_f(
      input nfc_pkg::nfc_op_e op,
      input logic [2:0] idx,
      input logic [27:0] a,
      input logic [7:0] wd
   );
      nfc_pkg::nfc_cyc_s c;
      logic [7:0] ab;
      case (idx)
         3'h1: ab = a[7:0];
         3'h2: ab = {4'h0, a[11:8]};
         3'h3: ab = a[19:12];
         default: ab = a[27:20];
      endcase
      c.kind = nfc_pkg::K_ADDR;
      c.data = ab;
      c.last = 1'b0;
      case (op)
         nfc_pkg::OP_PROG, nfc_pkg::OP_CBPG: begin
            if (idx == 3'h0) begin
               c.kind = nfc_pkg::K_CMD;
               c.data = (op == nfc_pkg::OP_PROG) ? `NFC_C_PROG : `NFC_C_RAND;
            end
            c.last = (idx == 3'h4);
         end
         nfc_pkg::OP_RAND: begin
            if (idx == 3'h0) begin
               c.kind = nfc_pkg::K_CMD;
               c.data = `NFC_C_RAND;
            end
            c.last = (idx == 3'h2);
         end
         nfc_pkg::OP_ERASE: begin
            // Page bits travel too; the flash itself drops them.
            c.data = (idx == 3'h1) ? a[19:12] : a[27:20];
            if (idx == 3'h0 || idx == 3'h3) begin
               c.kind = nfc_pkg::K_CMD;
               c.data = (idx == 3'h0) ? `NFC_C_ERASE : `NFC_C_ERCONF;
            end
            c.last = (idx == 3'h3);
         end
         nfc_pkg::OP_CBRD: begin
            if (idx == 3'h0 || idx == 3'h5) begin
               c.kind = nfc_pkg::K_CMD;
               c.data = (idx == 3'h0) ? `NFC_C_READ : `NFC_C_RDCB;
            end
            c.last = (idx == 3'h5);
         end
         nfc_pkg::OP_ID: begin
            if (idx == 3'h0) begin
               c.kind = nfc_pkg::K_CMD;
               c.data = `NFC_C_ID;
            end else begin
               c.data = `NFC_ID_ADDR;
            end
            c.last = (idx == 3'h1);
         end
         nfc_pkg::OP_RDARR: begin
            c.kind = (idx == 3'h0) ? nfc_pkg::K_CMD : nfc_pkg::K_RD;
            c.data = `NFC_C_READ;
            c.last = (idx == 3'h1);
         end
         nfc_pkg::OP_CONF, nfc_pkg::OP_STAT, nfc_pkg::OP_RESET: begin
            c.kind = nfc_pkg::K_CMD;
            c.data = (op == nfc_pkg::OP_CONF) ? `NFC_C_CONF :
               (op == nfc_pkg::OP_STAT) ? `NFC_C_STAT : `NFC_C_RESET;
            c.last = 1'b1;
         end
         nfc_pkg::OP_WDATA: begin
            c.kind = nfc_pkg::K_WR;
            c.data = wd;
            c.last = 1'b1;
         end
         default: begin
            c.kind = nfc_pkg::K_RD;
            c.last = 1'b1;
         end
      endcase
      return c;
   endfunction

   function automatic logic legal_f(
      input nfc_pkg::nfc_op_e op,
      input nfc_pkg::nfc_top_s s,
      input logic [15:0] pg
   );
      logic idle;
      logic ok;
      idle = !s.busy && !s.loading;
      case (op)
         nfc_pkg::OP_PROG: ok = idle && !(pg == s.last_page &&
            s.part_cnt >= 3'(PART_MAX));
         nfc_pkg::OP_RAND: ok = s.loading;
         nfc_pkg::OP_CONF: ok = s.loading && (s.loaded || s.cb);
         nfc_pkg::OP_WDATA: ok = s.loading;
         nfc_pkg::OP_CBPG: ok = idle && s.cb && !(pg == s.last_page &&
            s.part_cnt >= 3'(PART_MAX));
         nfc_pkg::OP_ERASE, nfc_pkg::OP_CBRD, nfc_pkg::OP_ID: ok = idle;
         nfc_pkg::OP_RDARR: ok = !s.busy;
         nfc_pkg::OP_STAT, nfc_pkg::OP_RESET, nfc_pkg::OP_RDBYTE: ok = 1'b1;
         default: ok = 1'b0;
      endcase
      return ok && s.st == nfc_pkg::S_IDLE;
   endfunction

   assign acc = WB_CYC_I && WB_STB_I && !q.ack;
   assign cur = step_f(q.op, q.idx, q.addr, q.wdata);

   always_comb begin
      nfc_pkg::nfc_op_e req_op;
      req_op = nfc_pkg::OP_NONE;
      d = q;
      if (SYS_CE_I) begin
         d.ack = acc;
         if (q.busy) begin
            if (q.wb_cnt != 4'h0) begin
               d.wb_cnt = q.wb_cnt - 4'h1;
            end else if (NAND_RB_N_I) begin
               d.busy = 1'b0;
            end
         end
         case (q.st)
            nfc_pkg::S_ISSUE: begin
               d.st = nfc_pkg::S_WAITC;
            end
            nfc_pkg::S_WAITC: begin
               if (eng_done) begin
                  if (cur.kind == nfc_pkg::K_RD) begin
                     d.rdata = eng_rdata;
                  end
                  if (!cur.last) begin
                     d.idx = q.idx + 3'h1;
                     d.st = nfc_pkg::S_ISSUE;
                     if (q.op == nfc_pkg::OP_RDARR) begin
                        d.stat_mode = 1'b0;
                     end
                  end else begin
                     d.st = nfc_pkg::S_IDLE;
                     case (q.op)
                        nfc_pkg::OP_PROG, nfc_pkg::OP_CBPG: begin
                           d.loading = 1'b1;
                           d.loaded = 1'b0;
                           d.stat_mode = 1'b0;
                        end
                        nfc_pkg::OP_WDATA: d.loaded = 1'b1;
                        nfc_pkg::OP_CONF: begin
                           // The flash keeps status output after this.
                           d.stat_mode = 1'b1;
                           d.loading = 1'b0;
                           d.loaded = 1'b0;
                           d.cb = 1'b0;
                           d.part_cnt = (q.page == q.last_page) ?
                              q.part_cnt + 3'h1 : 3'h1;
                           d.last_page = q.page;
                        end
                        nfc_pkg::OP_ERASE: begin
                           d.part_cnt = 3'h0;
                           // Erase leaves status output on.
                           d.stat_mode = 1'b1;
                        end
                        nfc_pkg::OP_CBRD: begin
                           d.cb = 1'b1;
                           d.stat_mode = 1'b0;
                        end
                        nfc_pkg::OP_STAT: d.stat_mode = 1'b1;
                        nfc_pkg::OP_ID, nfc_pkg::OP_RDARR: begin
                           d.stat_mode = 1'b0;
                        end
                        nfc_pkg::OP_RESET: begin
                           d.loading = 1'b0;
                           d.loaded = 1'b0;
                           d.cb = 1'b0;
                           d.stat_mode = 1'b0;
                        end
                        default: begin
                        end
                     endcase
                     if (q.op == nfc_pkg::OP_CONF || q.op == nfc_pkg::OP_ERASE
                        || q.op == nfc_pkg::OP_CBRD
                        || q.op == nfc_pkg::OP_RESET) begin
                        // Ready is not trusted until the busy edge can show.
                        d.busy = 1'b1;
                        d.wb_cnt = 4'(TWB_CYC);
                     end
                  end
               end
            end
            default: begin
               d.st = nfc_pkg::S_IDLE;
            end
         endcase
         if (acc && WB_WE_I) begin
            case (WB_ADR_I)
               `NFC_OFS_CTRL: begin
                  if (WB_SEL_I[1]) begin
                     d.wp_n = WB_DAT_I[`NFC_CTRL_WP_BIT];
                  end
                  if (WB_SEL_I[0]) begin
                     req_op = nfc_pkg::nfc_op_e'(WB_DAT_I[3:0]);
                  end
               end
               `NFC_OFS_ADDR: begin
                  if (q.st != nfc_pkg::S_IDLE) begin
                     d.err = 1'b1;
                  end else begin
                     for (int i = 0; i < 3; i++) begin
                        if (WB_SEL_I[i]) begin
                           d.addr[i*8 +: 8] = WB_DAT_I[i*8 +: 8];
                        end
                     end
                     if (WB_SEL_I[3]) begin
                        d.addr[27:24] = WB_DAT_I[27:24];
                     end
                  end
               end
               `NFC_OFS_WDATA: begin
                  if (WB_SEL_I[0]) begin
                     d.wdata = WB_DAT_I[7:0];
                     req_op = nfc_pkg::OP_WDATA;
                  end
               end
               `NFC_OFS_STAT: begin
                  if (WB_SEL_I[0] && WB_DAT_I[`NFC_STAT_ERR_BIT]) begin
                     d.err = 1'b0;
                  end
               end
               default: begin
               end
            endcase
         end
         if (req_op != nfc_pkg::OP_NONE) begin
            if (legal_f(req_op, q, q.addr[27:12])) begin
               d.op = req_op;
               d.st = nfc_pkg::S_ISSUE;
               d.idx = (req_op == nfc_pkg::OP_RDARR && !q.stat_mode) ?
                  3'h1 : 3'h0;
               if (req_op == nfc_pkg::OP_PROG || req_op == nfc_pkg::OP_CBPG)
               begin
                  d.page = q.addr[27:12];
               end
            end else begin
               d.err = 1'b1;
            end
         end
         if (acc && !WB_WE_I) begin
            case (WB_ADR_I)
               `NFC_OFS_CTRL: d.dat_o = {23'h0, q.wp_n, 4'h0, q.op};
               `NFC_OFS_ADDR: d.dat_o = {4'h0, q.addr};
               `NFC_OFS_WDATA: d.dat_o = {24'h0, q.wdata};
               `NFC_OFS_RDATA: d.dat_o = {24'h0, q.rdata};
               `NFC_OFS_STAT: d.dat_o = {21'h0, q.part_cnt, q.err,
                  q.stat_mode, q.cb, q.loaded, q.loading,
                  q.st != nfc_pkg::S_IDLE, NAND_RB_N_I, q.busy};
               default: d.dat_o = 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         q <= TOP_RST;
      end else begin
         q <= d;
      end
   end

   nfc_cycle u_cycle (
      .clk_i(SYS_CLK_I),
      .rst_n_i(RSTN_I),
      .ce_i(SYS_CE_I),
      .req_i(q.st == nfc_pkg::S_ISSUE),
      .cyc_i(cur),
      .io_i(NAND_IO_I),
      .pins_o(pins),
      .rdata_o(eng_rdata),
      .done_o(eng_done)
   );

   assign WB_DAT_O = q.dat_o;
   assign WB_ACK_O = q.ack;
   assign NAND_CE_N_O = pins.ce_n;
   assign NAND_CLE_O = pins.cle;
   assign NAND_ALE_O = pins.ale;
   assign NAND_WE_N_O = pins.we_n;
   assign NAND_RE_N_O = pins.re_n;
   assign NAND_IO_O = pins.io;
   assign NAND_IO_OE_N_O = pins.io_oe_n;
   assign NAND_WP_N_O = q.wp_n;

   default clocking cb_top @(posedge SYS_CLK_I);
   endclocking
   default disable iff (!RSTN_I);

   a_part_limit: assert property (
      q.part_cnt <= 3'(PART_MAX))
      else $error("Partial program count passed its limit.");
   a_prog_open: assert property (
      (q.st == nfc_pkg::S_ISSUE && q.op == nfc_pkg::OP_PROG) |->
      ((q.idx == 3'h0) == (cur.kind == nfc_pkg::K_CMD && cur.data == 8'h80)))
      else $error("Program did not open with its setup command.");
   a_erase_conf: assert property (
      (q.st == nfc_pkg::S_ISSUE && q.op == nfc_pkg::OP_ERASE && cur.last) |->
      (cur.kind == nfc_pkg::K_CMD && cur.data == 8'hD0 && q.idx == 3'h3))
      else $error("Erase did not end with its confirm after two addresses.");
   a_cb_dest: assert property (
      ($rose(q.st == nfc_pkg::S_ISSUE) && q.op == nfc_pkg::OP_CBPG
      && q.idx == 3'h0) |->
      (q.cb && !q.busy && $past(q.st) == nfc_pkg::S_IDLE))
      else $error("Copy-back program began before the source page was ready.");
   a_addr_count: assert property (
      (eng_done && SYS_CE_I && cur.last && q.op == nfc_pkg::OP_PROG) |->
      q.idx == 3'h4 ##1 q.loading)
      else $error("Program address phase was not four cycles long.");
   a_stat_resume: assert property (
      (q.st == nfc_pkg::S_WAITC && q.op == nfc_pkg::OP_RDARR
      && cur.kind == nfc_pkg::K_RD) |-> !q.stat_mode)
      else $error("Array read without leaving status mode.");
endmodule

// [rtl/nfc_host_end.sv]
// Empty design unit: the sequencer and its pin engine live elsewhere.

// [sim/nfc_flash_model.sv]
// Behavioural flash device driven by the host pins.
module nfc_flash_model #(
   parameter logic [6:0] BUSY = 7'h28,
   parameter logic [31:0] ID = 32'h5AC10015 // Arbitrary value.
) (
   input wire logic clk_i,
   input wire logic ce_n_i,
   input wire logic cle_i,
   input wire logic ale_i,
   input wire logic we_n_i,
   input wire logic re_n_i,
   input wire logic wp_n_i,
   input wire logic [7:0] io_i,
   output logic [7:0] io_o,
   output logic rb_n_o
);
   logic [7:0] mem = 8'hFF, dat = 8'hFF, q;
   logic [6:0] cnt = 7'h00;
   logic [1:0] mode = 2'h0, idp = 2'h0;
   logic we_q = 1'b1, re_q = 1'b1, ld = 1'b0, prg = 1'b0, era = 1'b0;
   logic in_rst = 1'b0;
   assign rb_n_o = (cnt == 7'h00);
   always_comb begin
      case (mode)
         2'h1: q = {wp_n_i, rb_n_o, rb_n_o, 5'h00};
         2'h2: q = ID[31 - 8 * idp -: 8];
         default: q = mem;
      endcase
   end
   // A released bus shows the inverse, so a stale byte never matches.
   assign io_o = (!ce_n_i && !re_n_i) ? q : ~q;
   always @(posedge clk_i) begin
      we_q <= we_n_i;
      re_q <= re_n_i;
      if (cnt != 7'h00) cnt <= cnt - 7'h01;
      if (cnt == 7'h01) in_rst <= 1'b0;
      if (mode == 2'h2 && !re_q && re_n_i) idp <= idp + 2'h1;
      if (!ce_n_i && !we_q && we_n_i && re_n_i) begin
         if (cle_i && !ale_i) begin
            if (rb_n_o || io_i == 8'h70
               || (io_i == 8'hFF && !in_rst)) begin
               case (io_i)
                  8'h00: mode <= 2'h0;
                  8'h70: mode <= 2'h1;
                  8'h90: begin
                     mode <= 2'h2;
                     idp <= 2'h0;
                  end
                  8'hFF: begin
                     cnt <= BUSY;
                     in_rst <= 1'b1;
                     mode <= 2'h1;
                     ld <= 1'b0;
                  end
                  8'h80: begin
                     prg <= 1'b1;
                     ld <= 1'b0;
                  end
                  8'h85: prg <= 1'b1;
                  8'h60: era <= 1'b1;
                  8'h35: begin
                     cnt <= BUSY;
                     dat <= mem;
                     ld <= 1'b1;
                  end
                  8'h10: if (prg && ld && wp_n_i) begin
                     cnt <= BUSY;
                     mem <= dat;
                     mode <= 2'h1;
                     prg <= 1'b0;
                     ld <= 1'b0;
                  end
                  8'hD0: if (era && wp_n_i) begin
                     cnt <= BUSY;
                     era <= 1'b0;
                     mem <= 8'hFF;
                     mode <= 2'h1;
                  end
                  default: ;
               endcase
            end
         end else if (!cle_i && !ale_i) begin
            dat <= io_i;
            ld <= 1'b1;
         end
      end
   end
endmodule

// [sim/tb_top.sv]
// Self-checking bench: host sequencer against the flash model.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] ID = 32'h5AC10015; // Arbitrary value.
   logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic wp = 1'b1, ack, ce_n, cle, ale, we_n, re_n, wp_n, oe_n, rb_n;
   logic [7:0] adr = 8'h00, io_h, io_f, d;
   logic [31:0] wdat = 32'h0, dat_o, rdat, a;
   int miscompares = 0, checks_done = 0, cycles = 0;
   int seed = 32'hC0DE6668;
   nfc_host dut (.SYS_CLK_I(clk), .RSTN_I(rst_n), .SYS_CE_I(1'b1),
      .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
      .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
      .NAND_CE_N_O(ce_n), .NAND_CLE_O(cle), .NAND_ALE_O(ale),
      .NAND_WE_N_O(we_n), .NAND_RE_N_O(re_n), .NAND_WP_N_O(wp_n),
      .NAND_IO_I(oe_n ? io_f : io_h), .NAND_IO_O(io_h),
      .NAND_IO_OE_N_O(oe_n), .NAND_RB_N_I(rb_n));
   nfc_flash_model #(.ID(ID)) flash (.clk_i(clk), .ce_n_i(ce_n),
      .cle_i(cle), .ale_i(ale), .we_n_i(we_n), .re_n_i(re_n),
      .wp_n_i(wp_n), .io_i(io_h), .io_o(io_f), .rb_n_o(rb_n));
   initial forever #10 clk = ~clk;
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // The ceiling allows several times the expected run length.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         print_verdict();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic logic [31:0] st_exp(input logic w);
      return {24'h0, w, 7'h60};
   endfunction
   // Ack and data are taken at the rising edge that shows ack high.
   task automatic wb(input logic w, input logic [7:0] ad,
      input logic [31:0] dt);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= ad;
      wdat <= dt;
      do @(posedge clk); while (ack !== 1'b1);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   // A new request is refused while the sequencer is active, or while busy unless it is status, reset or a byte read.
   task automatic idle_w();
      do wb(1'b0, 8'h10, 32'h0); while (rdat[2] !== 1'b0 || rdat[0] !== 1'b0);
   endtask
   task automatic op(input logic [3:0] c);
      wb(1'b1, 8'h00, {23'h0, wp, 4'h0, c});
      idle_w();
   endtask
   task automatic rd(input logic [3:0] c);
      op(c);
      wb(1'b0, 8'h0C, 32'h0);
   endtask
   task automatic prog(input int n);
      op(4'h1);
      chk({31'h0, rdat[7]}, {31'h0, n > 3});
      if (n < 4) begin
         d = 8'($random(seed));
         wb(1'b1, 8'h08, {24'h0, d});
         idle_w();
         op(4'h3);
         rd(4'hA);
         chk(rdat, st_exp(1'b1));
         rd(4'hB);
         chk(rdat, {24'h0, d});
      end
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      op(4'h9);
      op(4'h7);
      rd(4'hA);
      chk(rdat, st_exp(1'b1));
      $display("test reset finished");
      op(4'h8);
      for (int i = 0; i < 4; i++) begin
         rd(4'hA);
         chk(rdat, {24'h0, ID[31 - 8 * i -: 8]});
      end
      $display("test ident finished");
      a = $random(seed);
      wb(1'b1, 8'h04, {4'h0, a[27:0]});
      for (int i = 0; i < 5; i++) prog(i);
      $display("test program finished");
      wb(1'b1, 8'h10, 32'h80);
      op(4'h5);
      wb(1'b1, 8'h04, {4'h0, a[27:12] + 16'h1, a[11:0]});
      op(4'h6);
      op(4'h2);
      op(4'h3);
      chk({31'h0, rdat[7]}, 32'h0);
      rd(4'hA);
      chk(rdat, st_exp(1'b1));
      rd(4'hB);
      chk(rdat, {24'h0, d});
      $display("test copyback finished");
      wp = 1'b0;
      op(4'h4);
      op(4'h7);
      rd(4'hA);
      chk(rdat, st_exp(1'b0));
      rd(4'hB);
      chk(rdat, {24'h0, d});
      wp = 1'b1;
      op(4'h4);
      rd(4'hA);
      chk(rdat, st_exp(1'b1));
      rd(4'hB);
      chk(rdat, 32'hFF);
      op(4'h1);
      op(4'h3);
      chk({31'h0, rdat[7]}, 32'h1);
      wb(1'b0, 8'h14, 32'h0);
      chk(rdat, 32'h0);
      $display("test erase finished");
      print_verdict();
   end
endmodule
